// file: amsq_params.svh
`ifndef AMSQ_PARAMS_SVH
`define AMSQ_PARAMS_SVH
// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define AMSQ_SEQ_DEPTH 16
`define AMSQ_RES_BITS 12
`define AMSQ_WORD_BITS 16
`define AMSQ_CONV_NS 800
`define AMSQ_CLK_NS 10
`define AMSQ_CONV_CYCLES ((`AMSQ_CONV_NS + `AMSQ_CLK_NS - 1) / `AMSQ_CLK_NS)
// ----------------------------------------
// sequencer entry field positions
// ----------------------------------------
`define AMSQ_SE_END 0
`define AMSQ_SE_GAIN 1
`define AMSQ_SE_POL 2
`define AMSQ_SE_CH_LO 3
`define AMSQ_SE_TYPE 6
// ----------------------------------------
// mode pin codes {mode_sel_1, mode_sel_0}
// ----------------------------------------
`define AMSQ_MODE_PROG 2'h2
`define AMSQ_MODE_DIRECT_DEF 2'h3
`define AMSQ_MODE_SCAN_DEF 2'h0
`define AMSQ_MODE_SEQ_DEF 2'h1
`endif

// file: amsq_pkg.sv
package amsq_pkg;
   typedef enum logic [2:0] {
      AMSQ_IDLE = 3'b001,
      AMSQ_CONV = 3'b010,
      AMSQ_DOWN = 3'b100
   } amsq_state_t;
   typedef enum logic [1:0] {
      AMSQ_PD_NONE = 2'h0,
      AMSQ_PD_NAP = 2'h1,
      AMSQ_PD_SLEEP = 2'h2
   } amsq_pd_t;
endpackage

// file: amsq_fifo.sv
`timescale 1ns/10ps
module amsq_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr, rptr, next_wptr, next_rptr;
   logic push, pop;
   always_comb begin
      in_ready_out = (wptr - rptr) != (AW+1)'(DEPTH);
      out_valid_out = wptr != rptr;
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      out_data_out = mem[rptr[AW-1:0]];
   end
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
      if (push) begin
         mem[wptr[AW-1:0]] <= in_data_in;
      end
   end
endmodule

// file: amsq_core.sv
`timescale 1ns/10ps
`include "amsq_params.svh"
// Contract
// - 12-bit: the bit-9 output line carries end flag in readback, else result bit 9.
// - output drivers enabled only while read strobe and chip select are both low.
// - busy goes low at conversion start, high again when conversion completes.
// - in program/readback mode busy stays low until mode pin zero returns high.
// - gain select high means gain 1, low means gain 2.
// - polarity select low unipolar, high bipolar.
// - input type select low single-ended, high differential.
// - direct mode: config passes while write low, captured on write rising edge.
// - program mode: write rising edge stores entry and advances pointer.
// - readback: read low presents entry, read rising edge advances pointer.
// - conversion begins on falling edge of conversion start.
// - conversion start and read strobe ignored unless chip select low.
// - power-down low enters nap with select low, sleep with select high.
// - two mode pins choose mode; pin one high, pin zero low is program/readback.
// - output word 16 bits: result plus channel address and input type.
// - address and input type of each conversion accompany its result.
// - readback entry: type S6, channel S5-S3, polarity S2, gain S1, end S0.
// - result and address/config word load into output latch together.
// - start requests ignored while a conversion runs.
module amsq_core
   import amsq_pkg::*;
#(
   parameter int RES_BITS = `AMSQ_RES_BITS,
   parameter int SEQ_DEPTH = `AMSQ_SEQ_DEPTH,
   parameter int CONV_CYCLES = `AMSQ_CONV_CYCLES,
   parameter logic [1:0] MODE_DIRECT = `AMSQ_MODE_DIRECT_DEF,
   parameter logic [1:0] MODE_SCAN = `AMSQ_MODE_SCAN_DEF,
   parameter logic [1:0] MODE_SEQ = `AMSQ_MODE_SEQ_DEF
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // host strobes
   input wire logic chip_sel_n_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic conv_start_n_in,
   input wire logic power_down_n_in,
   // mode and configuration
   input wire logic mode_sel_0_in,
   input wire logic mode_sel_1_in,
   input wire logic [2:0] channel_addr_in,
   input wire logic input_type_select_in,
   input wire logic polarity_select_in,
   input wire logic gain_select_in,
   // conversion engine
   input wire logic [RES_BITS-1:0] sar_result_in,
   // parallel output pins
   output logic [15:0] data_out,
   output logic [15:0] data_oe_out,
   output logic busy_out,
   // applied multiplexer configuration
   output logic [2:0] mux_channel_out,
   output logic mux_input_type_echo,
   output logic mux_bipolar_out,
   output logic mux_gain2_out,
   output logic sample_out,
   // power state
   output logic nap_out,
   output logic sleep_out,
   // result stream
   output logic res_valid_out,
   input wire logic res_ready_in,
   output logic [15:0] res_data_out,
   output logic overrun_out
);
   initial begin
      if (RES_BITS != 10 && RES_BITS != 12) $error("resolution must be 10 or 12");
      if (SEQ_DEPTH != `AMSQ_SEQ_DEPTH) $error("sequencer depth must be 16");
      if (CONV_CYCLES < 1 || CONV_CYCLES > 300) $error("bad conversion length");
   end
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam int CONV_CYCLES_I = CONV_CYCLES;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [6:0] pack_cfg(input logic t, input logic [2:0] ch,
                                         input logic p, input logic g, input logic e);
      pack_cfg = {t, ch, p, g, e};
   endfunction
   // ----------------------------------------
   // edge detect and mode decode
   // ----------------------------------------
   logic cs_q, rd_q, wr_q, cv_q;
   logic [1:0] mode;
   logic prog_mode, direct_mode, seq_mode, scan_mode;
   logic start_fall, rd_fall, rd_rise, wr_rise, wr_low;
   logic busy_conv_q;
   always_comb begin
      mode = {mode_sel_1_in, mode_sel_0_in};
      prog_mode = mode == `AMSQ_MODE_PROG;
      direct_mode = mode == MODE_DIRECT;
      seq_mode = mode == MODE_SEQ;
      scan_mode = mode == MODE_SCAN;
      start_fall = cv_q && !conv_start_n_in && !chip_sel_n_in;
      rd_fall = rd_q && !rd_n_in && !chip_sel_n_in;
      rd_rise = !rd_q && rd_n_in && !cs_q;
      wr_rise = !wr_q && wr_n_in;
      wr_low = !wr_n_in;
   end
   // ----------------------------------------
   // direct configuration latch and sequencer
   // ----------------------------------------
   logic [6:0] seq_mem [SEQ_DEPTH];
   logic [3:0] seq_ptr, next_seq_ptr;
   logic [6:0] cfg_lat, next_cfg_lat, live_cfg, cur_cfg, rb_word, next_rb_word;
   logic [2:0] scan_ch, next_scan_ch;
   logic seq_wr;
   always_comb begin
      live_cfg = pack_cfg(input_type_select_in, channel_addr_in, polarity_select_in,
                          !gain_select_in, 1'b0);
      next_cfg_lat = (direct_mode && wr_low) ? live_cfg : cfg_lat;
      seq_wr = prog_mode && wr_rise;
      next_seq_ptr = seq_ptr;
      next_rb_word = rd_fall && prog_mode ? seq_mem[seq_ptr] : rb_word;
      next_scan_ch = scan_ch;
      if (seq_wr || (prog_mode && rd_rise)) begin
         next_seq_ptr = seq_ptr + 4'h1;
      end else if (seq_mode && start_fall && !busy_conv_q) begin
         next_seq_ptr = seq_mem[seq_ptr][`AMSQ_SE_END] ? 4'h0 : seq_ptr + 4'h1;
      end else if (!prog_mode && !seq_mode) begin
         next_seq_ptr = 4'h0;
      end
      if (scan_mode && start_fall && !busy_conv_q) begin
         next_scan_ch = scan_ch + 3'h1;
      end
      if (direct_mode) begin
         cur_cfg = wr_low ? live_cfg : cfg_lat;
      end else if (seq_mode) begin
         cur_cfg = seq_mem[seq_ptr];
      end else if (scan_mode) begin
         cur_cfg = {cfg_lat[6], scan_ch, cfg_lat[2:0]};
      end else begin
         cur_cfg = cfg_lat;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         cs_q <= 1'b1;
         rd_q <= 1'b1;
         wr_q <= 1'b1;
         cv_q <= 1'b1;
         seq_ptr <= 4'h0;
         cfg_lat <= 7'h00;
         rb_word <= 7'h00;
         scan_ch <= 3'h0;
      end else begin
         cs_q <= chip_sel_n_in;
         rd_q <= rd_n_in;
         wr_q <= wr_n_in;
         cv_q <= conv_start_n_in;
         seq_ptr <= next_seq_ptr;
         cfg_lat <= next_cfg_lat;
         rb_word <= next_rb_word;
         scan_ch <= next_scan_ch;
      end
      if (seq_wr) begin
         seq_mem[seq_ptr] <= live_cfg;
      end
   end
   // ----------------------------------------
   // conversion engine and output latch
   // ----------------------------------------
   amsq_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [6:0] conv_cfg, next_conv_cfg;
   logic [15:0] out_lat, next_out_lat, res_word;
   logic done, push, push_ready;
   always_comb begin
      busy_conv_q = state == AMSQ_CONV;
      next_state = state;
      next_cnt = cnt;
      next_conv_cfg = conv_cfg;
      done = 1'b0;
      case (state)
         AMSQ_IDLE: begin
            if (!power_down_n_in) begin
               next_state = AMSQ_DOWN;
            end else if (start_fall && !prog_mode) begin
               next_state = AMSQ_CONV;
               next_cnt = CW'(CONV_CYCLES);
               next_conv_cfg = cur_cfg;
            end
         end
         AMSQ_CONV: begin
            next_cnt = cnt - 1'b1;
            if (cnt == CW'(1)) begin
               next_state = AMSQ_IDLE;
               done = 1'b1;
            end
         end
         AMSQ_DOWN: begin
            if (power_down_n_in) next_state = AMSQ_IDLE;
         end
         default: next_state = AMSQ_IDLE;
      endcase
      res_word = '0;
      res_word[RES_BITS-1:0] = sar_result_in;
      res_word[15:12] = {conv_cfg[6], conv_cfg[5:3]};
      next_out_lat = done ? res_word : out_lat;
      push = done;
   end
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state <= AMSQ_IDLE;
         cnt <= '0;
         conv_cfg <= 7'h00;
         out_lat <= 16'h0000;
         overrun_out <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         conv_cfg <= next_conv_cfg;
         out_lat <= next_out_lat;
         overrun_out <= push && !push_ready;
      end
   end
   // ----------------------------------------
   // pins
   // ----------------------------------------
   always_comb begin
      busy_out = !(busy_conv_q || prog_mode);
      data_oe_out = (!rd_n_in && !chip_sel_n_in) ? 16'hFFFF : 16'h0000;
      data_out = out_lat;
      if (prog_mode) begin
         data_out[15:12] = rb_word[6:3];
         data_out[RES_BITS-1] = rb_word[`AMSQ_SE_POL];
         data_out[RES_BITS-2] = rb_word[`AMSQ_SE_GAIN];
         data_out[RES_BITS-3] = rb_word[`AMSQ_SE_END];
      end
      mux_channel_out = busy_conv_q ? conv_cfg[5:3] : cur_cfg[5:3];
      mux_input_type_echo = busy_conv_q ? conv_cfg[6] : cur_cfg[6];
      mux_bipolar_out = busy_conv_q ? conv_cfg[2] : cur_cfg[2];
      mux_gain2_out = busy_conv_q ? conv_cfg[1] : cur_cfg[1];
      sample_out = done;
      nap_out = state == AMSQ_DOWN && !chip_sel_n_in;
      sleep_out = state == AMSQ_DOWN && chip_sel_n_in;
   end
   amsq_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .in_valid_in(push),
      .in_ready_out(push_ready),
      .in_data_in(res_word),
      .out_valid_out(res_valid_out),
      .out_ready_in(res_ready_in),
      .out_data_out(res_data_out)
   );
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_start;
      state == AMSQ_IDLE && start_fall && !prog_mode && power_down_n_in;
   endsequence
   chk_busy_low_start: assert property (@(posedge mclk_in) disable iff (srst_in)
      s_start |=> !busy_out) else $error("busy not low after start");
   chk_busy_conv_len: assert property (@(posedge mclk_in) disable iff (srst_in)
      s_start |=> busy_conv_q [*1] ##(CONV_CYCLES_I) !busy_conv_q)
      else $error("conversion length wrong");
   chk_prog_busy: assert property (@(posedge mclk_in) disable iff (srst_in)
      prog_mode |-> !busy_out) else $error("busy high in program mode");
   chk_oe_gate: assert property (@(posedge mclk_in) disable iff (srst_in)
      (rd_n_in || chip_sel_n_in) |-> data_oe_out == 16'h0000) else $error("drivers on");
   chk_no_restart: assert property (@(posedge mclk_in) disable iff (srst_in)
      busy_conv_q && cnt > CW'(1) |=> busy_conv_q && cnt == $past(cnt) - 1'b1)
      else $error("conversion restarted");
   chk_ptr_write: assert property (@(posedge mclk_in) disable iff (srst_in)
      seq_wr |=> seq_ptr == $past(seq_ptr) + 4'h1) else $error("pointer not advanced");
   chk_latch_load: assert property (@(posedge mclk_in) disable iff (srst_in)
      done |=> out_lat[15:12] == $past(conv_cfg[6:3])) else $error("latch mismatch");
   chk_cs_ignore: assert property (@(posedge mclk_in) disable iff (srst_in)
      chip_sel_n_in && state == AMSQ_IDLE |=> state != AMSQ_CONV)
      else $error("start without select");
   chk_nap_sleep: assert property (@(posedge mclk_in) disable iff (srst_in)
      state == AMSQ_DOWN |-> nap_out != sleep_out) else $error("power state wrong");
   sequence s_rb_strobe;
      prog_mode && rd_rise && !seq_wr;
   endsequence
   chk_rb_advance: assert property (@(posedge mclk_in) disable iff (srst_in)
      s_rb_strobe |=> seq_ptr == $past(seq_ptr) + 4'h1)
      else $error("readback pointer stuck");
   sequence s_rb_latch;
      prog_mode && rd_fall;
   endsequence
   chk_rb_shown: assert property (@(posedge mclk_in) disable iff (srst_in)
      s_rb_latch ##1 prog_mode |-> data_out[RES_BITS-3] == rb_word[`AMSQ_SE_END])
      else $error("end flag not shown");
   chk_start_edge: assert property (@(posedge mclk_in) disable iff (srst_in)
      !busy_conv_q && !start_fall |=> !busy_conv_q) else $error("start without edge");
   chk_pd_enter: assert property (@(posedge mclk_in) disable iff (srst_in)
      state == AMSQ_IDLE && !power_down_n_in |=> state == AMSQ_DOWN)
      else $error("power down missed");
   chk_cfg_follow: assert property (@(posedge mclk_in) disable iff (srst_in)
      direct_mode && wr_low && !busy_conv_q |-> mux_channel_out == channel_addr_in)
      else $error("channel not passed through");
endmodule

// file: amsq_sink.sv
`timescale 1ns/10ps
// ----------------------------------------
// result consumer on the stream side
// ----------------------------------------
module amsq_sink (
   // clock
   input wire logic mclk_in,
   // stream
   input wire logic valid_in,
   output logic ready_out,
   // control
   input wire logic stall_in
);
   logic phase = 1'b0;
   always_ff @(posedge mclk_in) begin
      phase <= ~phase;
   end
   // half-rate acceptance keeps results waiting in the buffer
   assign ready_out = ~stall_in & phase;
endmodule

// file: amsq_core_bench.sv
`timescale 1ns/10ps
module amsq_core_bench;
   import amsq_pkg::*;
   localparam int CONV = 8;
   logic mclk_in, srst_in, cs_n, rd_n, wr_n, cv_n, pd_n, m0, m1;
   logic [2:0] ch, mch;
   logic ty, pol, gn, stall, rdy, busy, mdf, mbp, mg2, nap, slp, rv, ovr, smp;
   logic [11:0] sar;
   logic [15:0] dout, doe, rdat;
   logic [31:0] seed = 32'hE3B9;
   logic [31:0] r;
   logic [6:0] ent [16];
   logic [15:0] q [$];
   int fail_count = 0;
   int cmp_count = 0;
   int ovr_n = 0;
   int smp_n = 0;
   int conv_n = 0;
   int n;
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   amsq_core #(.CONV_CYCLES(CONV)) dut_u (
      .mclk_in(mclk_in), .srst_in(srst_in), .chip_sel_n_in(cs_n), .rd_n_in(rd_n),
      .wr_n_in(wr_n), .conv_start_n_in(cv_n), .power_down_n_in(pd_n),
      .mode_sel_0_in(m0), .mode_sel_1_in(m1), .channel_addr_in(ch),
      .input_type_select_in(ty), .polarity_select_in(pol), .gain_select_in(gn),
      .sar_result_in(sar), .data_out(dout), .data_oe_out(doe), .busy_out(busy),
      .mux_channel_out(mch), .mux_input_type_echo(mdf), .mux_bipolar_out(mbp),
      .mux_gain2_out(mg2), .sample_out(smp), .nap_out(nap), .sleep_out(slp),
      .res_valid_out(rv), .res_ready_in(rdy), .res_data_out(rdat), .overrun_out(ovr)
   );
   amsq_sink snk_u (.mclk_in(mclk_in), .valid_in(rv), .ready_out(rdy), .stall_in(stall));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_in);
      #1;
   endtask
   task automatic test_done();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one conversion; a second start is tried while it runs
   // want is {type, channel, polarity, gain of two}; the pins give it unless fix is set
   task automatic conv(input bit keep, input bit fix, input logic [5:0] want);
      logic [15:0] exp;
      logic [5:0] w;
      int c;
      conv_n++;
      r = rnd();
      {ch, ty, pol, gn} = r[5:0];
      sar = r[19:8];
      w = fix ? want : {ty, ch, pol, ~gn};
      exp = {w[5:2], sar};
      tick(2);
      chk({13'h0, mch}, {13'h0, w[4:2]});
      chk({13'h0, mdf, mbp, mg2}, {13'h0, w[5], w[1:0]});
      cv_n = 1'b0;
      c = 0;
      while (busy !== 1'b0 && c < 5) begin
         tick(1);
         c++;
      end
      chk({15'h0, busy}, 16'h0000);
      c = 0;
      while (busy === 1'b0 && c < 100) begin
         if (c == 1) cv_n = 1'b1;
         if (c == 3) cv_n = 1'b0;
         if (c == 4) cv_n = 1'b1;
         tick(1);
         c++;
      end
      chk(16'(c), 16'(CONV));
      chk(dout, exp);
      if (keep) q.push_back(exp);
      tick(2);
   endtask
   // ----------------------------------------
   // stream watcher: oldest note against each accepted word
   // ----------------------------------------
   always @(posedge mclk_in) begin
      if (rv === 1'b1 && rdy === 1'b1) begin
         chk({15'h0, q.size() > 0}, 16'h0001);
         if (q.size() > 0) chk(rdat, q.pop_front());
      end
      if (ovr === 1'b1) ovr_n++;
      if (smp === 1'b1) smp_n++;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {cs_n, rd_n, wr_n, cv_n, pd_n, m1, m0} = 7'h2F;
      {ch, ty, pol, gn, sar, stall} = '0;
      srst_in = 1'b1;
      tick(12);
      srst_in = 1'b0;
      tick(1);
      chk({15'h0, busy}, 16'h0001);
      chk(doe, 16'h0000);
      rd_n = 1'b0;
      tick(1);
      chk(doe, 16'hFFFF);
      cs_n = 1'b1;
      tick(1);
      chk(doe, 16'h0000);
      rd_n = 1'b1;
      cv_n = 1'b0;
      tick(3);
      chk({15'h0, busy}, 16'h0001);
      cv_n = 1'b1;
      cs_n = 1'b0;
      repeat (4) conv(1'b1, 1'b0, 6'h00);
      // write strobe high freezes the applied configuration
      wr_n = 1'b1;
      {ch, ty, pol, gn} = ~{ch, ty, pol, gn};
      tick(2);
      chk({13'h0, mch}, {13'h0, ~ch});
      wr_n = 1'b0;
      pd_n = 1'b0;
      tick(2);
      chk({14'h0, nap, slp}, 16'h0002);
      cs_n = 1'b1;
      tick(2);
      chk({14'h0, nap, slp}, 16'h0001);
      {pd_n, cs_n} = 2'b10;
      tick(2);
      // sixteen writes wrap the pointer back to the first entry
      // strobe already low, so entering the mode makes no stray rising edge
      {m1, m0} = 2'b10;
      tick(2);
      chk({15'h0, busy}, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         {ch, ty, pol, gn} = r[5:0];
         ent[i] = {ty, ch, pol, ~gn, 1'b0};
         wr_n = 1'b0;
         tick(1);
         wr_n = 1'b1;
         tick(1);
      end
      for (int i = 0; i < 16; i++) begin
         rd_n = 1'b0;
         tick(2);
         chk({9'h0, dout[15:9]}, {9'h0, ent[i]});
         chk({15'h0, busy}, 16'h0000);
         rd_n = 1'b1;
         tick(2);
      end
      {m0, wr_n} = 2'b10;
      tick(2);
      chk({15'h0, busy}, 16'h0001);
      // scan walks the channels from zero; sequenced mode replays the stored entries
      {ch, ty, pol, gn} = 6'h0D;
      tick(1);
      {m1, m0} = 2'b00;
      for (int k = 0; k < 3; k++) begin
         conv(1'b1, 1'b1, {1'b1, 3'(k), 2'b00});
      end
      {m1, m0} = 2'b01;
      for (int k = 0; k < 3; k++) begin
         conv(1'b1, 1'b1, ent[k][6:1]);
      end
      {m1, m0} = 2'b11;
      // sink stalls: sixteen results fit, the next is dropped
      stall = 1'b1;
      repeat (16) conv(1'b1, 1'b0, 6'h00);
      conv(1'b0, 1'b0, 6'h00);
      chk(16'(ovr_n), 16'h0001);
      chk({15'h0, rv}, 16'h0001);
      stall = 1'b0;
      n = 0;
      while (q.size() > 0 && n < 200) begin
         tick(1);
         n++;
      end
      tick(4);
      chk({15'h0, rv}, 16'h0000);
      chk(16'(q.size()), 16'h0000);
      chk(16'(smp_n), 16'(conv_n));
      test_done();
   end
   initial begin
      #(60000 * 10);
      fail_count++;
      test_done();
   end
endmodule
